// >>> core/dbsp_map.svh
// How it works
// - write: address at t, data K/K# t+1
// - read: words at C# t+1, C t+2
// - stopped clocks: outputs hold previous state
// - second burst address inverts address LSB
// - x18 select 0 only: bits 8:0
// - x18 select 1 only: bits 17:9
// - x18 both selects low: all bits
// - x18 both selects high: nothing written
// - x36 all selects low: all bits
// - x36 select 0 only: bits 8:0
// - x36 selects 1,2,3 write their bytes
// - x36 all selects high: nothing written
// - byte selects sampled per data word
// - power-up deselected, outputs tri-stated
// - inputs on K edges, outputs on C, or on K in single clock mode
// - controller inserts no-op read to write
// - read after write returns newest data
// - single clock mode strapped at power-on
`ifndef DBSP_MAP_SVH
`define DBSP_MAP_SVH
`define DBSP_ADDR_W 4
`define DBSP_DATA_W 18
`define DBSP_BYTE_W 9
`define DBSP_NOP_GAP 2
`define DBSP_WR_SR_W 3
`define DBSP_RD_SR_W 4
`define DBSP_WR_W1_TAP 1
`define DBSP_WR_W2_TAP 2
`define DBSP_RD_TAP 3
`endif

// >>> core/dbsp_pkg.sv
package dbsp_pkg;
  // command issued on a K rise
  typedef enum logic [1:0] {
    DBSP_CMD_NOP = 2'b00,
    DBSP_CMD_READ = 2'b01,
    DBSP_CMD_WRITE = 2'b10
  } dbsp_cmd_t;
endpackage : dbsp_pkg

// >>> core/dbsp_if.sv
`timescale 1ns/1ps
`include "dbsp_map.svh"
interface dbsp_if #(
  parameter int ADDR_W = `DBSP_ADDR_W,
  parameter int DATA_W = `DBSP_DATA_W
);
  localparam int NBYTE = DATA_W / `DBSP_BYTE_W;
  logic k;
  logic kn;
  logic c;
  logic cn;
  logic load_strobe_n;
  logic rw_sel;
  logic [ADDR_W-1:0] addr;
  logic [NBYTE-1:0] byte_write_select_n;
  logic [DATA_W-1:0] dq_mem;
  logic dq_mem_oe;
  logic [DATA_W-1:0] dq_ctl;
  logic dq_ctl_oe;
  logic [DATA_W-1:0] dq;
  // shared data wire, memory drive wins, idle reads as zero
  assign dq = dq_mem_oe ? dq_mem : (dq_ctl_oe ? dq_ctl : '0);
  modport mem (
    input k, kn, c, cn, load_strobe_n, rw_sel, addr, byte_write_select_n, dq,
    output dq_mem, dq_mem_oe
  );
  modport ctl (
    output k, kn, c, cn, load_strobe_n, rw_sel, addr, byte_write_select_n, dq_ctl,
    output dq_ctl_oe,
    input dq
  );
endinterface : dbsp_if

// >>> core/dbsp_mem_end.sv
`timescale 1ns/1ps
`include "dbsp_map.svh"
module dbsp_mem_end #(
  parameter int ADDR_W = `DBSP_ADDR_W,
  parameter int DATA_W = `DBSP_DATA_W
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  dbsp_if.mem link,
  output logic single_clock_mode_o,
  output logic read_drive_o
);
  import dbsp_pkg::*;
  localparam int NBYTE = DATA_W / `DBSP_BYTE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // only the x18 and x36 organisations exist
  if (DATA_W != 18 && DATA_W != 36) begin : g_bad_width
    $error("dbsp_mem_end: DATA_W must be 18 or 36");
  end

  logic k_q_reg;
  logic out_q_reg;
  logic strap_done_reg;
  logic single_reg;
  logic [DATA_W-1:0] mem_reg [DEPTH];
  logic wr_cap_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic w2_pend_reg;
  logic [ADDR_W-1:0] w2_addr_reg;
  logic rd_cap_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic rd_arm_reg;
  logic [ADDR_W-1:0] rd_arm_addr_reg;
  logic r2_pend_reg;
  logic [ADDR_W-1:0] r2_addr_reg;
  logic [DATA_W-1:0] dq_reg;
  logic oe_reg;
  logic out_lvl;
  logic k_rise;
  logic k_fall;
  logic out_rise;
  logic out_fall;

  // merge one word under its active-low byte selects
  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w, input logic [NBYTE-1:0] sel_n);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int b = 0; b < NBYTE; b++) begin
      if (!sel_n[b]) begin
        res[b*`DBSP_BYTE_W +: `DBSP_BYTE_W] = new_w[b*`DBSP_BYTE_W +: `DBSP_BYTE_W];
      end
    end
    return res;
  endfunction : merge_bytes

  // partner address of the burst
  function automatic logic [ADDR_W-1:0] burst_next(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:1], ~a[0]};
  endfunction : burst_next

  // edges seen as level changes; no change means the clocks stand still
  assign out_lvl = single_reg ? link.k : link.c;
  assign k_rise = link.k & ~k_q_reg;
  assign k_fall = ~link.k & k_q_reg;
  assign out_rise = strap_done_reg & out_lvl & ~out_q_reg;
  assign out_fall = strap_done_reg & ~out_lvl & out_q_reg;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      k_q_reg <= 1'b0;
      out_q_reg <= 1'b1;
    end else begin
      k_q_reg <= link.k;
      out_q_reg <= out_lvl;
    end
  end

  // strap caught at the first K rise, never again
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_reg <= 1'b0;
      single_reg <= 1'b0;
    end else if (k_rise && !strap_done_reg) begin
      strap_done_reg <= 1'b1;
      single_reg <= link.c & link.cn;
    end
  end

  // command capture on K rise
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_cap_reg <= 1'b0;
      rd_cap_reg <= 1'b0;
      wr_addr_reg <= '0;
      rd_addr_reg <= '0;
      rd_arm_reg <= 1'b0;
      rd_arm_addr_reg <= '0;
      w2_pend_reg <= 1'b0;
      w2_addr_reg <= '0;
    end else if (k_rise) begin
      // a high load strobe ignores the read/write select
      wr_cap_reg <= ~link.load_strobe_n & ~link.rw_sel;
      rd_cap_reg <= ~link.load_strobe_n & link.rw_sel;
      if (!link.load_strobe_n) begin
        wr_addr_reg <= link.addr;
        rd_addr_reg <= link.addr;
      end
      rd_arm_reg <= rd_cap_reg;
      rd_arm_addr_reg <= rd_addr_reg;
      w2_pend_reg <= wr_cap_reg;
      w2_addr_reg <= burst_next(wr_addr_reg);
    end else if (k_fall) begin
      w2_pend_reg <= 1'b0;
    end
  end

  // array writes: first word on K rise, second on K# rise
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (k_rise && wr_cap_reg) begin
      // selects taken fresh with each word
      mem_reg[wr_addr_reg] <= merge_bytes(mem_reg[wr_addr_reg], link.dq,
          link.byte_write_select_n);
    end else if (k_fall && w2_pend_reg) begin
      mem_reg[w2_addr_reg] <= merge_bytes(mem_reg[w2_addr_reg], link.dq,
          link.byte_write_select_n);
    end
  end

  // read launch; array is already updated so a read right after a write
  // sees the newest data without a separate compare path
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dq_reg <= '0;
      oe_reg <= 1'b0;
      r2_pend_reg <= 1'b0;
      r2_addr_reg <= '0;
    end else if (out_fall && rd_arm_reg) begin
      dq_reg <= mem_reg[rd_arm_addr_reg];
      oe_reg <= 1'b1;
      r2_pend_reg <= 1'b1;
      r2_addr_reg <= burst_next(rd_arm_addr_reg);
    end else if (out_rise) begin
      if (r2_pend_reg) begin
        dq_reg <= mem_reg[r2_addr_reg];
        r2_pend_reg <= 1'b0;
      end else begin
        oe_reg <= 1'b0;
      end
    end
    // no edge: everything holds
  end

  assign link.dq_mem = dq_reg;
  assign link.dq_mem_oe = oe_reg;
  assign single_clock_mode_o = single_reg;
  assign read_drive_o = oe_reg;
endmodule : dbsp_mem_end

// >>> core/dbsp_ctl_end.sv
`timescale 1ns/1ps
`include "dbsp_map.svh"
module dbsp_ctl_end #(
  parameter int ADDR_W = `DBSP_ADDR_W,
  parameter int DATA_W = `DBSP_DATA_W,
  parameter int NOP_GAP = `DBSP_NOP_GAP
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  dbsp_if.ctl link,
  input wire logic clk_run_i,
  input wire logic single_mode_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [2*DATA_W-1:0] req_wdata_i,
  input wire logic [2*(DATA_W/`DBSP_BYTE_W)-1:0] req_mask_n_i,
  output logic req_ready_o,
  output logic [2*DATA_W-1:0] rdata_o,
  output logic rdata_valid_o
);
  import dbsp_pkg::*;
  localparam int NBYTE = DATA_W / `DBSP_BYTE_W;

  if (DATA_W != 18 && DATA_W != 36) begin : g_bad_width
    $error("dbsp_ctl_end: DATA_W must be 18 or 36");
  end
  if (NOP_GAP < 1 || NOP_GAP > 7) begin : g_bad_gap
    $error("dbsp_ctl_end: NOP_GAP must be 1..7");
  end

  logic strap_done_reg;
  logic single_reg;
  logic k_reg;
  logic c_reg;
  logic cn_reg;
  logic strobe_n_reg;
  logic rw_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [NBYTE-1:0] sel_n_reg;
  logic [DATA_W-1:0] dq_reg;
  logic oe_reg;
  logic ready_reg;
  logic [2:0] gap_reg;
  logic [2:0] gap_next;
  logic [2*DATA_W-1:0] wbuf_reg;
  logic [2*NBYTE-1:0] wmask_reg;
  logic [DATA_W-1:0] hold_reg;
  logic [NBYTE-1:0] hold_mask_reg;
  logic [`DBSP_WR_SR_W-1:0] wsr_reg;
  logic [`DBSP_RD_SR_W-1:0] rsr_reg;
  logic cap1_reg;
  logic cap2_reg;
  logic [DATA_W-1:0] lo_reg;
  logic [2*DATA_W-1:0] rdata_reg;
  logic rvalid_reg;
  logic run;
  logic k_next;
  logic rise_tog;
  logic accept;
  dbsp_cmd_t cmd_next;

  // a request is taken only on an edge that raises K
  assign run = strap_done_reg & clk_run_i;
  assign k_next = run ? ~k_reg : k_reg;
  assign rise_tog = run & ~k_reg;
  assign accept = rise_tog & req_valid_i & ready_reg;

  always_comb begin
    cmd_next = DBSP_CMD_NOP;
    if (accept) begin
      cmd_next = req_write_i ? DBSP_CMD_WRITE : DBSP_CMD_READ;
    end
  end

  // no-op cycles after a read keep the bus from turning too soon
  always_comb begin
    gap_next = gap_reg;
    case (cmd_next)
      DBSP_CMD_READ: gap_next = 3'(NOP_GAP);
      DBSP_CMD_WRITE: gap_next = 3'd0;
      DBSP_CMD_NOP: begin
        if (rise_tog && gap_reg != 3'd0) begin
          gap_next = gap_reg - 3'd1;
        end
      end
      default: gap_next = gap_reg;
    endcase
  end

  // strap level presented from reset, caught once after release
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_reg <= 1'b0;
      single_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      single_reg <= single_mode_i;
    end
  end

  // link clocks; C tracks K with no skew, or both held high
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      k_reg <= 1'b0;
      c_reg <= 1'b1;
      cn_reg <= 1'b1;
    end else begin
      k_reg <= k_next;
      c_reg <= (strap_done_reg ? single_reg : single_mode_i) | k_next;
      cn_reg <= (strap_done_reg ? single_reg : single_mode_i) | ~k_next | ~strap_done_reg;
    end
  end

  // command pins change only with a K rise
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strobe_n_reg <= 1'b1;
      rw_reg <= 1'b1;
      addr_reg <= '0;
      ready_reg <= 1'b0;
      gap_reg <= 3'd0;
      wbuf_reg <= '0;
      wmask_reg <= '1;
    end else begin
      if (rise_tog) begin
        strobe_n_reg <= ~accept;
      end
      if (accept) begin
        rw_reg <= ~req_write_i;
        addr_reg <= req_addr_i;
        wbuf_reg <= req_wdata_i;
        wmask_reg <= req_mask_n_i;
      end
      gap_reg <= gap_next;
      ready_reg <= strap_done_reg & ~k_next & (gap_next == 3'd0);
    end
  end

  // write data: word one on K rise t+1, word two on K# rise t+1
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wsr_reg <= '0;
      dq_reg <= '0;
      oe_reg <= 1'b0;
      sel_n_reg <= '1;
      hold_reg <= '0;
      hold_mask_reg <= '1;
    end else if (run) begin
      wsr_reg <= {wsr_reg[`DBSP_WR_SR_W-2:0], cmd_next == DBSP_CMD_WRITE};
      if (wsr_reg[`DBSP_WR_W1_TAP]) begin
        dq_reg <= wbuf_reg[DATA_W-1:0];
        sel_n_reg <= wmask_reg[NBYTE-1:0];
        oe_reg <= 1'b1;
        hold_reg <= wbuf_reg[2*DATA_W-1:DATA_W];
        hold_mask_reg <= wmask_reg[2*NBYTE-1:NBYTE];
      end else if (wsr_reg[`DBSP_WR_W2_TAP]) begin
        dq_reg <= hold_reg;
        sel_n_reg <= hold_mask_reg;
      end else begin
        oe_reg <= 1'b0;
        sel_n_reg <= '1;
      end
    end
  end

  // read return: memory launches word one a cycle after the fourth
  // half-period, so capture runs on plain clocks, not on link edges
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsr_reg <= '0;
      cap1_reg <= 1'b0;
      cap2_reg <= 1'b0;
      lo_reg <= '0;
      rdata_reg <= '0;
      rvalid_reg <= 1'b0;
    end else begin
      if (run) begin
        rsr_reg <= {rsr_reg[`DBSP_RD_SR_W-2:0], cmd_next == DBSP_CMD_READ};
      end
      cap1_reg <= run & rsr_reg[`DBSP_RD_TAP];
      cap2_reg <= cap1_reg;
      rvalid_reg <= cap2_reg;
      if (cap1_reg) begin
        lo_reg <= link.dq;
      end
      if (cap2_reg) begin
        rdata_reg <= {link.dq, lo_reg};
      end
    end
  end

  assign link.k = k_reg;
  assign link.kn = ~k_reg;
  assign link.c = c_reg;
  assign link.cn = cn_reg;
  assign link.load_strobe_n = strobe_n_reg;
  assign link.rw_sel = rw_reg;
  assign link.addr = addr_reg;
  assign link.byte_write_select_n = sel_n_reg;
  assign link.dq_ctl = dq_reg;
  assign link.dq_ctl_oe = oe_reg;
  assign req_ready_o = ready_reg;
  assign rdata_o = rdata_reg;
  assign rdata_valid_o = rvalid_reg;
endmodule : dbsp_ctl_end

// >>> test/dbsp_link_asserts.sv
`timescale 1ns/1ps
module dbsp_link_asserts #(
  parameter int DATA_W = 18
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic k,
  input wire logic kn,
  input wire logic c,
  input wire logic cn,
  input wire logic load_strobe_n,
  input wire logic rw_sel,
  input wire logic [DATA_W/9-1:0] byte_write_select_n,
  input wire logic [DATA_W-1:0] dq_mem,
  input wire logic dq_mem_oe,
  input wire logic dq_ctl_oe
);
  // one domain, so one clock and one reset for all checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  // commands as the memory end sees them on a k rise
  sequence rd_cmd;
    $rose(k) && !load_strobe_n && rw_sel;
  endsequence
  sequence wr_cmd;
    $rose(k) && !load_strobe_n && !rw_sel;
  endsequence
  a_kn_inverse: assert property (kn == !k)
    else $error("kn is not the inverse of k");
  // memory data moves only one cycle after a link clock edge
  a_launch_edge: assert property ($changed(dq_mem) |-> $past(k, 1) != $past(k, 2))
    else $error("memory data moved without a clock edge");
  a_cmd_on_rise: assert property ($changed(load_strobe_n) |-> $rose(k))
    else $error("load strobe moved off a k rise");
  // an earlier read may still drive right at the command, so look just before launch
  a_read_launch: assert property (rd_cmd |-> ##3 !dq_mem_oe ##1 dq_mem_oe)
    else $error("read data not launched on time");
  // a write on the next k rise keeps the enable up for its own words
  a_write_data: assert property (wr_cmd |-> ##2 dq_ctl_oe ##1 dq_ctl_oe
    ##1 (dq_ctl_oe == $past(!load_strobe_n && !rw_sel, 2)))
    else $error("write data window wrong");
  a_read_gap: assert property (rd_cmd |-> ##2 load_strobe_n ##2 load_strobe_n)
    else $error("no idle gap after a read");
  a_bus_single: assert property (!(dq_mem_oe && dq_ctl_oe))
    else $error("both ends drive the data wire");
  // k frozen means clocks stopped; outputs must not move
  a_stop_hold: assert property ($stable(k) [*2] |-> $stable(dq_mem) && $stable(dq_mem_oe))
    else $error("outputs moved while clocks stopped");
  a_idle_hiz: assert property ((load_strobe_n && $changed(k)) [*8] |-> !dq_mem_oe)
    else $error("memory still drives after idle cycles");
  a_out_clocks: assert property (!(c && cn) |-> c == k && cn == !k)
    else $error("output clock pair not tied to k");
  a_sel_idle: assert property (!dq_ctl_oe |-> &byte_write_select_n)
    else $error("byte selects active outside write data");
  c_read: cover property (rd_cmd);
  c_write: cover property (wr_cmd);
  c_stop: cover property ($stable(k) [*4]);
  c_single: cover property (c && cn && $rose(k));
endmodule : dbsp_link_asserts

// >>> test/ddr_burst2_sram_port_tb.sv
`timescale 1ns/1ps
module ddr_burst2_sram_port_tb;
  import dbsp_pkg::*;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic run = 1'b1;
  logic smode = 1'b0;
  logic vld = 1'b0;
  logic wr = 1'b0;
  logic [3:0] ad = 4'h0;
  logic [35:0] wd = 36'h0_0000_0000;
  logic [3:0] mk = 4'hf;
  logic rdy, rv, scm, rdrv;
  logic [35:0] rd;
  logic [17:0] mem [16];
  logic [71:0] wd36 = 72'h00_0000_0000_0000_0000;
  logic [7:0] mk36 = 8'hff;
  logic rdy36, rv36, scm36, rdrv36;
  logic [71:0] rd36;
  logic [35:0] mem36 [16];
  int miscompares = 0;
  int checks = 0;
  always #50 clock_i = ~clock_i;
  // both ends face each other across one link
  dbsp_if lnk ();
  dbsp_mem_end u_dbsp_mem_end (.clock_i(clock_i), .nrst_i(nrst_i), .link(lnk),
    .single_clock_mode_o(scm), .read_drive_o(rdrv));
  dbsp_ctl_end u_dbsp_ctl_end (.clock_i(clock_i), .nrst_i(nrst_i), .link(lnk),
    .clk_run_i(run), .single_mode_i(smode), .req_valid_i(vld), .req_write_i(wr),
    .req_addr_i(ad), .req_wdata_i(wd), .req_mask_n_i(mk), .req_ready_o(rdy),
    .rdata_o(rd), .rdata_valid_o(rv));
  dbsp_link_asserts #(.DATA_W(18)) u_dbsp_link_asserts (.clock_i(clock_i),
    .nrst_i(nrst_i), .k(lnk.k), .kn(lnk.kn), .c(lnk.c), .cn(lnk.cn),
    .load_strobe_n(lnk.load_strobe_n), .rw_sel(lnk.rw_sel),
    .byte_write_select_n(lnk.byte_write_select_n), .dq_mem(lnk.dq_mem),
    .dq_mem_oe(lnk.dq_mem_oe), .dq_ctl_oe(lnk.dq_ctl_oe));
  // wide pair runs the same requests, so the four-byte selects get exercised
  dbsp_if #(.DATA_W(36)) lnk36 ();
  dbsp_mem_end #(.DATA_W(36)) u_dbsp_mem_end_w36 (.clock_i(clock_i), .nrst_i(nrst_i),
    .link(lnk36), .single_clock_mode_o(scm36), .read_drive_o(rdrv36));
  dbsp_ctl_end #(.DATA_W(36)) u_dbsp_ctl_end_w36 (.clock_i(clock_i), .nrst_i(nrst_i),
    .link(lnk36), .clk_run_i(run), .single_mode_i(smode), .req_valid_i(vld),
    .req_write_i(wr), .req_addr_i(ad), .req_wdata_i(wd36), .req_mask_n_i(mk36),
    .req_ready_o(rdy36), .rdata_o(rd36), .rdata_valid_o(rv36));
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: data %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit
  // byte b of a word is written only where its select is low
  function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n,
      input logic [1:0] s);
    merge = o;
    if (!s[0]) merge[8:0] = n[8:0];
    if (!s[1]) merge[17:9] = n[17:9];
  endfunction : merge
  // four nine-bit bytes, each kept where its select is high
  function automatic logic [35:0] merge36(input logic [35:0] o, input logic [35:0] n,
      input logic [3:0] s);
    merge36 = o;
    for (int b = 0; b < 4; b++) begin
      if (!s[b]) merge36[b*9 +: 9] = n[b*9 +: 9];
    end
  endfunction : merge36
  // request held from one edge until the edge that sees ready
  task automatic issue(input logic w, input logic [3:0] a, input logic [35:0] d,
      input logic [3:0] m);
    int n;
    @(posedge clock_i);
    vld <= 1'b1;
    wr <= w;
    ad <= a;
    wd <= d;
    mk <= m;
    // wide words: each narrow half beside its inverse; masks shuffled per word
    wd36 <= {~d[35:18], d[35:18], ~d[17:0], d[17:0]};
    mk36 <= {m[3:2], m[1:0], m[1:0], m[3:2]};
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while ((rdy & rdy36) !== 1'b1 && n < 40);
    // a request that is never taken must not pass silently
    if ((rdy & rdy36) !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t: request never taken", $time);
    end
    vld <= 1'b0;
  endtask : issue
  // model keeps the burst pair at a and a with bit 0 flipped
  task automatic wr_burst(input logic [3:0] a, input logic [35:0] d, input logic [3:0] m);
    issue(1'b1, a, d, m);
    mem[a] = merge(mem[a], d[17:0], m[1:0]);
    mem[a ^ 4'h1] = merge(mem[a ^ 4'h1], d[35:18], m[3:2]);
    mem36[a] = merge36(mem36[a], {~d[17:0], d[17:0]}, {m[1:0], m[3:2]});
    mem36[a ^ 4'h1] = merge36(mem36[a ^ 4'h1], {~d[35:18], d[35:18]}, {m[3:2], m[1:0]});
  endtask : wr_burst
  task automatic rd_burst(input logic [3:0] a);
    int n;
    issue(1'b0, a, 36'h0_0000_0000, 4'hf);
    n = 0;
    while (rv !== 1'b1 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    cmp_bit(rv, 1'b1);
    cmp_bit(rv36, 1'b1);
    cmp(rd, {mem[a ^ 4'h1], mem[a]});
    cmp(rd36, {mem36[a ^ 4'h1], mem36[a]});
  endtask : rd_burst
  // watchdog at 20000 cycles, far above the several hundred cycles of the tests
  initial begin
    #2_000_000;
    miscompares++;
    $display("ERROR %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    cmp_bit(rdrv, 1'b0);
    cmp_bit(lnk.dq_mem_oe, 1'b0);
    cmp_bit(scm, 1'b0);
    cmp_bit(rdrv36, 1'b0);
    cmp_bit(scm36, 1'b0);
    for (int i = 0; i < 16; i += 2) begin
      wr_burst(4'(i), {18'h0_3c3c + 18'(i), 18'h1_2481 + 18'(i)}, 4'h0);
    end
    for (int i = 0; i < 16; i++) begin
      rd_burst(4'(i));
    end
    $display("test fill done");
    // every mask on both words, each read straight after its write
    for (int m = 0; m < 16; m++) begin
      wr_burst(4'h6, {18'h3_ffff ^ 18'(m * 37), 18'h2_0101 * 18'(m + 1)}, 4'(m));
      rd_burst(4'h6);
      rd_burst(4'h7);
    end
    $display("test masks done");
    // stop the link clocks while idle, then resume
    run <= 1'b0;
    repeat (12) @(posedge clock_i);
    cmp_bit(lnk.dq_mem_oe, 1'b0);
    cmp_bit(rdrv, 1'b0);
    cmp_bit(rdrv36, 1'b0);
    run <= 1'b1;
    rd_burst(4'h6);
    $display("test stop done");
    // strap only takes effect through a fresh reset
    nrst_i <= 1'b0;
    smode <= 1'b1;
    repeat (8) @(posedge clock_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    cmp_bit(scm, 1'b1);
    cmp_bit(scm36, 1'b1);
    cmp_bit(lnk.c & lnk.cn, 1'b1);
    wr_burst(4'h9, 36'h5_a5a5_0f0f, 4'h0);
    rd_burst(4'h8);
    $display("test single done");
    summarize();
  end
endmodule : ddr_burst2_sram_port_tb
